// >>> design/tsc_temp_comp.v
// Temperature sensor averaging, source selection, window alarm, interrupt
// status and open-loop polynomial clock compensation.
// Assumes the sensor word is asynchronous and changes slowly, and that the
// register master uses one-cycle strobes with read data one cycle later.
//
// The implementer's own choice: the address-and-strobe port.
`include "tsc_consts.vh"

module tsc_temp_comp #(
    parameter SAMPLE_CYCLES = `TSC_SAMPLE_CYCLES,
    parameter AVG_LOG2 = `TSC_AVG_LOG2
) (
    input wire core_clk, // System clock, 100 MHz
    input wire reset, // Synchronous, active high
    input wire [15:0] addr, // Register byte address
    input wire [7:0] wr_data, // Register write data
    input wire wr_en, // Write strobe
    input wire rd_en, // Read strobe
    output reg [7:0] rd_data, // Read data, cycle after strobe
    input wire [15:0] sense_raw, // Raw sensor word, asynchronous
    input wire [31:0] nco_word, // Oscillator tuning word
    input wire [31:0] tdc_word, // Converter scale word
    output reg [31:0] nco_word_comp, // Compensated oscillator word
    output reg [31:0] tdc_word_comp, // Compensated converter word
    output reg [15:0] temp_loop0, // Temperature to loop channel 0
    output reg [15:0] temp_loop1, // Temperature to loop channel 1
    output reg [31:0] compensation_correction, // Fraction, 2^-32 units
    output reg irq // Level interrupt
);

    // Sensor word synchroniser; the first stage is read only by the second
    reg [15:0] sense_meta;
    reg [15:0] sense_sync;

    // Averaging
    reg [7:0] div_cnt;
    reg [AVG_LOG2-1:0] smp_cnt;
    reg [AVG_LOG2+15:0] avg_acc;
    reg [15:0] die_temp;
    reg result_pulse;

    // Software registers
    reg [15:0] ext_temp;
    reg [2:0] src_sel;
    reg [15:0] low_lim;
    reg [15:0] high_lim;
    reg [15:0] coef [0:5];
    reg [1:0] designate;
    reg [7:0] irq_enable;
    reg [7:0] irq_status;
    reg [7:0] wr_hold;
    reg [7:0] rd_hold;
    reg alarm;

    // Polynomial evaluation
    reg [2:0] step;
    reg [31:0] acc;
    reg [15:0] temp_sys;

    wire [AVG_LOG2+15:0] acc_next;
    wire [31:0] horner;
    wire [63:0] sq;
    wire [31:0] fpe_corr;
    wire [47:0] mul;
    reg [7:0] next_rd;
    // Each process owns its loop index so none is written from two places
    integer i;
    integer j;
    integer k;

    // Offsets are computed at integer width; only the low 16 bits decode
    function hit;
        input [15:0] a;
        input integer base;
        begin
            hit = (a == base[15:0]);
        end
    endfunction

    // Sign-extend a 16-bit coefficient to accumulator width
    function [31:0] widen;
        input [15:0] c;
        begin
            widen = {{16{c[15]}}, c};
        end
    endfunction

    // Word times (1 + corr), corr a signed fraction in 2^-32 units
    function [31:0] scale;
        input [31:0] word;
        input [31:0] corr;
        reg [64:0] prod;
        begin
            prod = $signed({1'b0, word}) * $signed(corr);
            scale = word + prod[63:32];
        end
    endfunction

    always @(posedge core_clk) begin
        sense_meta <= sense_raw;
        sense_sync <= sense_meta;
    end

    assign acc_next = avg_acc + {{AVG_LOG2{sense_sync[15]}}, sense_sync};

    // One sample every 40 ns, one result per 4096 samples
    always @(posedge core_clk) begin
        if (reset) begin
            div_cnt <= 8'h00;
            smp_cnt <= {AVG_LOG2{1'b0}};
            avg_acc <= {(AVG_LOG2+16){1'b0}};
            die_temp <= `TSC_RST_WORD16;
            result_pulse <= 1'b0;
        end else begin
            result_pulse <= 1'b0;
            if (div_cnt == SAMPLE_CYCLES - 1) begin
                div_cnt <= 8'h00;
                smp_cnt <= smp_cnt + 1'b1;
                if (&smp_cnt) begin
                    // Arithmetic shift keeps the result signed
                    die_temp <= acc_next[AVG_LOG2+15:AVG_LOG2];
                    avg_acc <= {(AVG_LOG2+16){1'b0}};
                    result_pulse <= 1'b1;
                end else begin
                    avg_acc <= acc_next;
                end
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

    // Live window detector, no latching
    always @(posedge core_clk) begin
        if (reset) begin
            alarm <= 1'b0;
        end else begin
            alarm <= ($signed(die_temp) > $signed(high_lim)) ||
                     ($signed(die_temp) < $signed(low_lim));
        end
    end

    // Register writes; the low byte waits in wr_hold until the high byte
    // lands so the logic never sees a half-updated 16-bit value
    always @(posedge core_clk) begin
        if (reset) begin
            ext_temp <= `TSC_RST_WORD16;
            src_sel <= `TSC_RST_SEL;
            low_lim <= `TSC_RST_WORD16;
            high_lim <= `TSC_RST_WORD16;
            designate <= 2'h0;
            irq_enable <= `TSC_RST_BYTE;
            wr_hold <= `TSC_RST_BYTE;
            for (i = 0; i < 6; i = i + 1) begin
                coef[i] <= `TSC_RST_WORD16;
            end
        end else if (wr_en) begin
            if (hit(addr, `TSC_ADDR_EXT_TEMP) ||
                hit(addr, `TSC_ADDR_LOW_LIM) ||
                hit(addr, `TSC_ADDR_HIGH_LIM)) begin
                wr_hold <= wr_data;
            end
            // Stored as written; no rescaling is applied
            if (hit(addr, `TSC_ADDR_EXT_TEMP + 16'h0001)) begin
                ext_temp <= {wr_data, wr_hold};
            end
            if (hit(addr, `TSC_ADDR_SRC_SEL)) begin
                src_sel <= wr_data[2:0];
            end
            if (hit(addr, `TSC_ADDR_LOW_LIM + 16'h0001)) begin
                low_lim <= {wr_data, wr_hold};
            end
            if (hit(addr, `TSC_ADDR_HIGH_LIM + 16'h0001)) begin
                high_lim <= {wr_data, wr_hold};
            end
            for (i = 0; i < 6; i = i + 1) begin
                if (hit(addr, `TSC_ADDR_COEF_BASE + 2 * i)) begin
                    wr_hold <= wr_data;
                end
                if (hit(addr, `TSC_ADDR_COEF_BASE + 2 * i + 1)) begin
                    coef[i] <= {wr_data, wr_hold};
                end
            end
            if (hit(addr, `TSC_ADDR_DESIGNATE)) begin
                designate <= wr_data[1:0];
            end
            if (hit(addr, `TSC_ADDR_IRQ_ENABLE)) begin
                irq_enable <= wr_data;
            end
        end
    end

    // Sticky interrupt status; a setting event beats a same-cycle clear
    always @(posedge core_clk) begin
        if (reset) begin
            irq_status <= `TSC_RST_BYTE;
            irq <= 1'b0;
        end else begin
            if (wr_en && hit(addr, `TSC_ADDR_IRQ_CLEAR)) begin
                irq_status[`TSC_IRQ_RESULT_BIT] <= result_pulse ||
                    (irq_status[`TSC_IRQ_RESULT_BIT] &&
                     !wr_data[`TSC_IRQ_RESULT_BIT]);
                irq_status[`TSC_IRQ_ALARM_BIT] <= alarm ||
                    (irq_status[`TSC_IRQ_ALARM_BIT] &&
                     !wr_data[`TSC_IRQ_ALARM_BIT]);
            end else begin
                irq_status[`TSC_IRQ_RESULT_BIT] <=
                    irq_status[`TSC_IRQ_RESULT_BIT] || result_pulse;
                irq_status[`TSC_IRQ_ALARM_BIT] <=
                    irq_status[`TSC_IRQ_ALARM_BIT] || alarm;
            end
            irq <= |(irq_status & irq_enable);
        end
    end

    // Read decode; a low-byte read snapshots the high byte for the pair
    always @* begin
        next_rd = 8'h00;
        if (hit(addr, `TSC_ADDR_EXT_TEMP)) begin
            next_rd = ext_temp[7:0];
        end
        if (hit(addr, `TSC_ADDR_EXT_TEMP + 16'h0001)) begin
            next_rd = rd_hold;
        end
        if (hit(addr, `TSC_ADDR_SRC_SEL)) begin
            next_rd = {5'h00, src_sel};
        end
        if (hit(addr, `TSC_ADDR_LOW_LIM)) begin
            next_rd = low_lim[7:0];
        end
        if (hit(addr, `TSC_ADDR_LOW_LIM + 16'h0001)) begin
            next_rd = rd_hold;
        end
        if (hit(addr, `TSC_ADDR_HIGH_LIM)) begin
            next_rd = high_lim[7:0];
        end
        if (hit(addr, `TSC_ADDR_HIGH_LIM + 16'h0001)) begin
            next_rd = rd_hold;
        end
        for (j = 0; j < 6; j = j + 1) begin
            if (hit(addr, `TSC_ADDR_COEF_BASE + 2 * j)) begin
                next_rd = coef[j][7:0];
            end
            if (hit(addr, `TSC_ADDR_COEF_BASE + 2 * j + 1)) begin
                next_rd = rd_hold;
            end
        end
        if (hit(addr, `TSC_ADDR_DESIGNATE)) begin
            next_rd = {6'h00, designate};
        end
        if (hit(addr, `TSC_ADDR_IRQ_ENABLE)) begin
            next_rd = irq_enable;
        end
        if (hit(addr, `TSC_ADDR_ALARM_STAT)) begin
            next_rd = {7'h00, alarm};
        end
        if (hit(addr, `TSC_ADDR_DIE_TEMP)) begin
            next_rd = die_temp[7:0];
        end
        if (hit(addr, `TSC_ADDR_DIE_TEMP + 16'h0001)) begin
            next_rd = rd_hold;
        end
        // The clear register is write-only and reads as zero
        if (hit(addr, `TSC_ADDR_IRQ_STAT)) begin
            next_rd = irq_status;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            rd_data <= `TSC_RST_BYTE;
            rd_hold <= `TSC_RST_BYTE;
        end else begin
            rd_data <= rd_en ? next_rd : `TSC_RST_BYTE;
            if (rd_en) begin
                if (hit(addr, `TSC_ADDR_EXT_TEMP)) begin
                    rd_hold <= ext_temp[15:8];
                end
                if (hit(addr, `TSC_ADDR_LOW_LIM)) begin
                    rd_hold <= low_lim[15:8];
                end
                if (hit(addr, `TSC_ADDR_HIGH_LIM)) begin
                    rd_hold <= high_lim[15:8];
                end
                if (hit(addr, `TSC_ADDR_DIE_TEMP)) begin
                    rd_hold <= die_temp[15:8];
                end
                for (k = 0; k < 6; k = k + 1) begin
                    if (hit(addr, `TSC_ADDR_COEF_BASE + 2 * k)) begin
                        rd_hold <= coef[k][15:8];
                    end
                end
            end
        end
    end

    // Per-consumer source selection
    always @(posedge core_clk) begin
        if (reset) begin
            temp_sys <= `TSC_RST_WORD16;
            temp_loop0 <= `TSC_RST_WORD16;
            temp_loop1 <= `TSC_RST_WORD16;
        end else begin
            temp_sys <= src_sel[`TSC_SEL_SYS_BIT] ?
                ext_temp : die_temp;
            temp_loop0 <= src_sel[`TSC_SEL_LOOP0_BIT] ?
                ext_temp : die_temp;
            temp_loop1 <= src_sel[`TSC_SEL_LOOP1_BIT] ?
                ext_temp : die_temp;
        end
    end

    // Horner evaluation, one multiply per cycle; coefficient k is the
    // weight of T^k with T in 1/128 degree units
    assign mul = $signed(acc) * $signed(temp_sys);
    assign horner = mul[38:7] + widen(coef[5 - step]);

    always @(posedge core_clk) begin
        if (reset) begin
            step <= 3'h0;
            acc <= 32'h00000000;
            compensation_correction <= 32'h00000000;
        end else begin
            if (step == 3'h0) begin
                acc <= widen(coef[5]);
                step <= 3'h1;
            end else begin
                acc <= horner;
                if (step == `TSC_POLY_ORDER) begin
                    // Negated source error, a fraction of nominal
                    compensation_correction <= 32'h00000000 - horner;
                    step <= 3'h0;
                end else begin
                    step <= step + 1'b1;
                end
            end
        end
    end

    // Period form for converters: -e/(1+e) ~ -e + e^2, second order is
    // enough because the error stays in the ppm range
    assign sq = $signed(compensation_correction) *
                $signed(compensation_correction);
    assign fpe_corr = sq[63:32] - compensation_correction;

    // Apply only to designated consumers, else pass the word through
    always @(posedge core_clk) begin
        if (reset) begin
            nco_word_comp <= 32'h00000000;
            tdc_word_comp <= 32'h00000000;
        end else begin
            nco_word_comp <= designate[`TSC_DES_NCO_BIT] ?
                scale(nco_word, compensation_correction) : nco_word;
            tdc_word_comp <= designate[`TSC_DES_TDC_BIT] ?
                scale(tdc_word, fpe_corr) : tdc_word;
        end
    end

endmodule // tsc_temp_comp

// >>> design/tsc_consts.vh
// Constants for the temperature source, alarm and clock compensation block.
// Assumes byte-wide register access on a 16-bit address port.
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH

`define TSC_ADDR_EXT_TEMP 16'h2900
`define TSC_ADDR_SRC_SEL 16'h2902
`define TSC_ADDR_LOW_LIM 16'h2903
`define TSC_ADDR_HIGH_LIM 16'h2905
`define TSC_ADDR_COEF_BASE 16'h2910
`define TSC_ADDR_DESIGNATE 16'h291c
`define TSC_ADDR_IRQ_ENABLE 16'h291d
`define TSC_ADDR_IRQ_CLEAR 16'h291e
`define TSC_ADDR_ALARM_STAT 16'h3002
`define TSC_ADDR_DIE_TEMP 16'h3003
`define TSC_ADDR_IRQ_STAT 16'h300c

`define TSC_SEL_SYS_BIT 0
`define TSC_SEL_LOOP0_BIT 1
`define TSC_SEL_LOOP1_BIT 2
`define TSC_DES_NCO_BIT 0
`define TSC_DES_TDC_BIT 1
`define TSC_IRQ_RESULT_BIT 0
`define TSC_IRQ_ALARM_BIT 4

`define TSC_RST_SEL 3'h0
`define TSC_RST_WORD16 16'h0000
`define TSC_RST_BYTE 8'h00

`define TSC_CLK_PERIOD_NS 10
`define TSC_SAMPLE_PERIOD_NS 40
`define TSC_SAMPLE_CYCLES (`TSC_SAMPLE_PERIOD_NS / `TSC_CLK_PERIOD_NS)
`define TSC_AVG_LOG2 12
`define TSC_TEMP_FRAC 7
`define TSC_POLY_ORDER 5

`endif

// >>> verification/tsc_temp_comp_monitor.sv
// Port checker for the temperature source, alarm and compensation block.
// Bound into tsc_temp_comp; shadows the registers it needs from the bus.
module tsc_temp_comp_monitor #(
    parameter SAMPLE_CYCLES = 4,
    parameter AVG_LOG2 = 12
) (
    input wire core_clk, // clock
    input wire reset, // sync reset
    input wire [15:0] addr, // address
    input wire [7:0] wr_data, // write data
    input wire wr_en, // write strobe
    input wire rd_en, // read strobe
    input logic [7:0] rd_data, // read data
    input wire [15:0] sense_raw, // sensor word
    input wire [31:0] nco_word, // tuning word
    input wire [31:0] tdc_word, // scale word
    input logic [31:0] nco_word_comp, // compensated
    input logic [31:0] tdc_word_comp, // compensated
    input logic [15:0] temp_loop0, // loop 0 temp
    input logic [15:0] temp_loop1, // loop 1 temp
    input logic [31:0] compensation_correction, // correction
    input logic irq // interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] quiet;
    logic [7:0] lo_hold;
    logic [15:0] ext_sh, low_sh, high_sh;
    logic [2:0] sel_sh;
    logic [1:0] des_sh;
    logic [7:0] ien_sh;
    wire settled = quiet >= 4'h3;
    // Only low-then-high pairs are tracked; a lone high write is not modelled
    always @(posedge core_clk) begin
        if (reset) begin
            {quiet, ext_sh, low_sh, high_sh, sel_sh, des_sh, ien_sh} <= '0;
        end else if (wr_en) begin
            quiet <= 4'h0;
            lo_hold <= wr_data;
            case (addr)
                16'h2901: ext_sh <= {wr_data, lo_hold};
                16'h2902: sel_sh <= wr_data[2:0];
                16'h2904: low_sh <= {wr_data, lo_hold};
                16'h2906: high_sh <= {wr_data, lo_hold};
                16'h291c: des_sh <= wr_data[1:0];
                16'h291d: ien_sh <= wr_data;
                default: ;
            endcase
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    sequence s_alarm_read;
        settled && rd_en && addr == 16'h3002;
    endsequence
    chk_rd_idle_zero: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data not zero after idle cycle");
    chk_loop0_ext: assert property (
        settled && sel_sh[1] |-> temp_loop0 == ext_sh)
        else $error("loop 0 temperature not external");
    chk_loop1_ext: assert property (
        settled && sel_sh[2] |-> temp_loop1 == ext_sh)
        else $error("loop 1 temperature not external");
    chk_nco_pass: assert property (
        settled && !des_sh[0] |-> nco_word_comp == $past(nco_word))
        else $error("undesignated tuning word altered");
    chk_tdc_pass: assert property (
        settled && !des_sh[1] |-> tdc_word_comp == $past(tdc_word))
        else $error("undesignated scale word altered");
    chk_irq_masked: assert property (
        settled && ien_sh == 8'h00 |-> !irq)
        else $error("interrupt high while all masked");
    chk_alarm_inside: assert property (
        s_alarm_read ##0 (low_sh == 16'h8000 && high_sh == 16'h7fff)
        |=> rd_data[0] == 1'b0)
        else $error("alarm set with full window");
    chk_alarm_outside: assert property (
        s_alarm_read ##0 (low_sh == 16'h7fff && high_sh == 16'h8000)
        |=> rd_data[0] == 1'b1)
        else $error("alarm clear with empty window");
endmodule // tsc_temp_comp_monitor

bind tsc_temp_comp tsc_temp_comp_monitor #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .AVG_LOG2(AVG_LOG2)
) i_tsc_temp_comp_monitor (
    .core_clk(core_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sense_raw(sense_raw),
    .nco_word(nco_word), .tdc_word(tdc_word), .irq(irq),
    .nco_word_comp(nco_word_comp), .tdc_word_comp(tdc_word_comp),
    .temp_loop0(temp_loop0), .temp_loop1(temp_loop1),
    .compensation_correction(compensation_correction)
);

// >>> verification/tsc_temp_comp_tb_top.sv
// Self-checking bench for the temperature source, alarm and compensation.
// Drives every port itself; averaging is shortened to 8 samples per result, one sample per cycle.
module tsc_temp_comp_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [15:0] addr = 16'h0000, sense_raw = 16'h0000, w;
    logic [7:0] wr_data = 8'h00, b;
    logic [31:0] nco_word = 32'h0, tdc_word = 32'h0, cr;
    wire [7:0] rd_data;
    wire [31:0] nco_word_comp, tdc_word_comp, compensation_correction;
    wire [15:0] temp_loop0, temp_loop1;
    wire irq;
    int num_errors = 0, tests_run = 0, cycles = 0, seed = 15;
    logic signed [15:0] sa = 16'sh0, sb = 16'sh0, v, ext, lo, hi;
    logic toggle = 1'b0, a;
    logic [3:0] m;
    int dlo[6] = '{-1, 0, 1, -5, 0, 0};
    int dhi[6] = '{1, 0, 5, -1, 0, 0};
    logic [15:0] regs[9] = '{16'h2900, 16'h2901, 16'h2902, 16'h2903,
        16'h2904, 16'h2905, 16'h2906, 16'h3002, 16'h2950};

    tsc_temp_comp #(.SAMPLE_CYCLES(1), .AVG_LOG2(3)) i_tsc_temp_comp (
        .core_clk(core_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sense_raw(sense_raw),
        .nco_word(nco_word), .tdc_word(tdc_word), .irq(irq),
        .nco_word_comp(nco_word_comp), .tdc_word_comp(tdc_word_comp),
        .temp_loop0(temp_loop0), .temp_loop1(temp_loop1),
        .compensation_correction(compensation_correction)
    );

    always #5 core_clk = ~core_clk;
    // Alternating two values makes the 8-sample average exact
    always @(posedge core_clk) begin
        sense_raw <= (toggle && sense_raw == sa) ? sb : sa;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict;
        end
    end

    task automatic note(input logic ok, input logic [31:0] got, exp);
        tests_run++;
        if (!ok) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_reg(input logic [15:0] got, exp);
        note(got === exp, {16'h0, got}, {16'h0, exp});
    endtask
    task automatic check_out(input logic [31:0] got, exp);
        note(got === exp, got, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        addr <= ad;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] ad, output logic [7:0] d);
        @(posedge core_clk);
        addr <= ad;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic wr16(input logic [15:0] ad, input logic [15:0] d);
        wr(ad, d[7:0]);
        wr(ad + 16'h1, d[15:8]);
    endtask
    task automatic rd16(input logic [15:0] ad, output logic [15:0] d);
        rd(ad, d[7:0]);
        rd(ad + 16'h1, d[15:8]);
    endtask
    function automatic logic [31:0] exp_corr(logic signed [15:0] t);
        return -((int'(t) >>> 7) + 1);
    endfunction
    function automatic logic [31:0] exp_apply(logic [31:0] wd, x);
        return wd + 32'((longint'(wd) * longint'($signed(x))) >>> 32);
    endfunction
    function automatic logic [31:0] exp_fpe(logic [31:0] x);
        return 32'((longint'($signed(x)) * longint'($signed(x))) >>> 32) - x;
    endfunction
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        foreach (regs[i]) begin
            rd(regs[i], b);
            check_reg({8'h00, b}, 16'h0000);
        end
        v = 16'($random(seed) % 2000);
        ext = 16'($random(seed) % 2000);
        sa <= v;
        sb <= ext;
        toggle <= 1'b1;
        idle(60);
        rd16(16'h3003, w);
        check_reg(w, 16'((int'(v) + int'(ext)) >>> 1));
        toggle <= 1'b0;
        wr(16'h3003, 8'hff);
        idle(40);
        rd16(16'h3003, w);
        check_reg(w, v);
        wr16(16'h2900, ext);
        wr16(16'h2912, 16'h0001);
        wr16(16'h2910, 16'h0001);
        for (int s = 0; s < 8; s++) begin
            @(posedge core_clk);
            nco_word <= $random(seed);
            tdc_word <= $random(seed);
            wr(16'h2902, 8'(s));
            idle(20);
            check_reg(temp_loop0, s[1] ? ext : v);
            check_reg(temp_loop1, s[2] ? ext : v);
            check_out(compensation_correction,
                exp_corr(s[0] ? ext : v));
        end
        wr16(16'h2900, 16'h2f80);
        wr(16'h291c, 8'h03);
        cr = exp_corr(16'h2f80);
        repeat (4) begin
            m = 4'($random(seed));
            @(posedge core_clk);
            nco_word <= {1'b0, m, 27'h0};
            tdc_word <= {1'b0, m, 27'h0};
            idle(20);
            check_out(nco_word_comp, exp_apply(nco_word, cr));
            check_out(tdc_word_comp, exp_apply(tdc_word, exp_fpe(cr)));
        end
        wr(16'h291d, 8'h10);
        for (int c = 0; c < 6; c++) begin
            lo = (c == 4) ? 16'h8000 : (c == 5) ? 16'h7fff : 16'(v + dlo[c]);
            hi = (c == 4) ? 16'h7fff : (c == 5) ? 16'h8000 : 16'(v + dhi[c]);
            a = (v > hi) || (v < lo);
            wr16(16'h2903, lo);
            wr16(16'h2905, hi);
            wr(16'h291e, 8'h10);
            idle(4);
            rd(16'h3002, b);
            check_reg({8'h00, b}, {15'h0, a});
            rd(16'h300c, b);
            check_reg({11'h0, b[4], 4'h0}, {11'h0, a, 4'h0});
            check_reg({15'h0, irq}, {15'h0, a});
        end
        wr(16'h291d, 8'h00);
        idle(3);
        check_reg({15'h0, irq}, 16'h0000);
        print_verdict;
    end
endmodule // tsc_temp_comp_tb_top
